// ==== logic/smie_exec.sv ====
// Wishbone-controlled execution unit for right shift, file move and indirect load.
`timescale 1ns/1ps
`include "smie_consts.svh"
module smie_exec
  import smie_pkg::*;
(
  // Clock, reset and enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Status
  output logic busy_o
);

  // ****************************************
  // State
  // ****************************************
  logic [7:0] mem_reg [0:127];
  logic [15:0] instr_reg;
  logic [7:0] w_reg;
  logic c_reg;
  logic z_reg;
  logic [15:0] ptr0_reg;
  logic [15:0] ptr1_reg;
  logic [15:0] eaddr_reg;
  logic ack_reg;
  logic [31:0] rdat_reg;
  smie_state_e state_reg;
  smie_state_e state_next;

  // ****************************************
  // Helper functions
  // ****************************************
  function automatic smie_instr_s smie_decode(input logic [15:0] iw);
    smie_decode.op = smie_op_e'(iw[`SMIE_OP_HI:`SMIE_OP_LO]);
    smie_decode.d = iw[`SMIE_D_BIT];
    smie_decode.f = iw[`SMIE_F_HI:0];
    smie_decode.n = iw[`SMIE_N_BIT];
    smie_decode.rel = iw[`SMIE_REL_BIT];
    smie_decode.mm = iw[`SMIE_MM_HI:`SMIE_MM_LO];
    smie_decode.k = iw[`SMIE_K_HI:0];
  endfunction : smie_decode

  // The window registers carry no storage; they alias the byte their pointer names.
  function automatic logic [6:0] smie_file_addr(input logic [6:0] f, input logic [15:0] p0,
                                                input logic [15:0] p1);
    if (f == `SMIE_WIN0_F) begin
      smie_file_addr = p0[6:0];
    end else if (f == `SMIE_WIN1_F) begin
      smie_file_addr = p1[6:0];
    end else begin
      smie_file_addr = f;
    end
  endfunction : smie_file_addr

  function automatic logic [15:0] smie_merge16(input logic [15:0] old, input logic [15:0] nw,
                                               input logic [1:0] sel);
    smie_merge16 = {sel[1] ? nw[15:8] : old[15:8], sel[0] ? nw[7:0] : old[7:0]};
  endfunction : smie_merge16

  // ****************************************
  // Decode and datapath
  // ****************************************
  smie_instr_s ins;
  logic exec_fire;
  logic [6:0] faddr;
  logic [7:0] src;
  logic [7:0] lsr_res;
  logic [15:0] ptr_sel;
  smie_ptr_req_s preq;
  smie_ptr_rsp_s prsp;
  logic [7:0] ind_data;

  assign ins = smie_decode(instr_reg);
  assign exec_fire = ce_i && (state_reg == SMIE_ST_EXEC);
  assign faddr = smie_file_addr(ins.f, ptr0_reg, ptr1_reg);
  assign src = mem_reg[faddr];
  assign lsr_res = {1'b0, src[7:1]};
  assign ptr_sel = ins.n ? ptr1_reg : ptr0_reg;
  assign preq = '{ptr: ptr_sel, rel: ins.rel, mm: ins.mm, k: ins.k};
  // Only the low seven address bits reach the 128-byte data store.
  assign ind_data = mem_reg[prsp.ea[6:0]];
  assign busy_o = (state_reg == SMIE_ST_EXEC);

  smie_ptr_unit u_ptr (
    .req_i(preq),
    .rsp_o(prsp)
  );

  // ****************************************
  // Wishbone decode
  // ****************************************
  logic req;
  logic wr_now;
  logic in_mem;
  logic [31:0] rd_mux;

  assign req = wb_cyc_i && wb_stb_i;
  // Writes land on the edge where the master sees ack, never earlier.
  assign wr_now = ce_i && req && wb_we_i && ack_reg;
  assign in_mem = (wb_adr_i[11:9] == `SMIE_MEM_SEL);

  always_comb begin
    rd_mux = 32'h00000000;
    if (in_mem) begin
      rd_mux[7:0] = mem_reg[wb_adr_i[8:2]];
    end else begin
      case (wb_adr_i)
        `SMIE_ADR_INSTR: rd_mux[15:0] = instr_reg;
        `SMIE_ADR_WREG: rd_mux[7:0] = w_reg;
        `SMIE_ADR_STATUS: rd_mux[1:0] = {z_reg, c_reg};
        `SMIE_ADR_PTR0: rd_mux[15:0] = ptr0_reg;
        `SMIE_ADR_PTR1: rd_mux[15:0] = ptr1_reg;
        `SMIE_ADR_EADDR: rd_mux[15:0] = eaddr_reg;
        default: rd_mux = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else if (ce_i) begin
      // A request waits out the execution cycle so read data never predates the result.
      ack_reg <= req && !ack_reg && (state_reg != SMIE_ST_EXEC);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_reg <= 32'h00000000;
    end else if (ce_i && req && !ack_reg && state_reg != SMIE_ST_EXEC) begin
      rdat_reg <= rd_mux;
    end
  end

  // A frozen cycle must not show ack, or the master would finish a write the block never takes.
  assign wb_ack_o = ack_reg && ce_i;
  assign wb_dat_o = rdat_reg;

  // ****************************************
  // Sequencer
  // ****************************************
  always_comb begin
    case (state_reg)
      SMIE_ST_IDLE: begin
        if (wr_now && !in_mem && wb_adr_i == `SMIE_ADR_INSTR && wb_sel_i[1:0] != 2'b00) begin
          state_next = SMIE_ST_EXEC;
        end else begin
          state_next = SMIE_ST_IDLE;
        end
      end
      SMIE_ST_EXEC: state_next = SMIE_ST_IDLE;
      default: state_next = SMIE_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= SMIE_ST_IDLE;
    end else if (ce_i) begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      instr_reg <= `SMIE_RST_INSTR;
    end else if (wr_now && !in_mem && wb_adr_i == `SMIE_ADR_INSTR) begin
      instr_reg <= smie_merge16(instr_reg, wb_dat_i[15:0], wb_sel_i[1:0]);
    end
  end

  // ****************************************
  // Working register
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      w_reg <= `SMIE_RST_BYTE;
    end else if (exec_fire) begin
      case (ins.op)
        // shift to W when d is 0
        SMIE_OP_LSR: if (!ins.d) w_reg <= lsr_res;
        // move to W when d is 0
        SMIE_OP_MOVE_FILE_OP: if (!ins.d) w_reg <= src;
        SMIE_OP_INDIRECT_LOAD_OP: w_reg <= ind_data;
        default: w_reg <= w_reg;
      endcase
    end else if (wr_now && !in_mem && wb_adr_i == `SMIE_ADR_WREG && wb_sel_i[0]) begin
      w_reg <= wb_dat_i[7:0];
    end
  end

  // ****************************************
  // Status flags
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      c_reg <= 1'b0;
      z_reg <= 1'b0;
    end else if (exec_fire) begin
      case (ins.op)
        SMIE_OP_LSR: begin
          c_reg <= src[0];
          z_reg <= (lsr_res == 8'h00);
        end
        SMIE_OP_MOVE_FILE_OP: z_reg <= (src == 8'h00);
        SMIE_OP_INDIRECT_LOAD_OP: z_reg <= (ind_data == 8'h00);
        default: z_reg <= z_reg;
      endcase
    end else if (wr_now && !in_mem && wb_adr_i == `SMIE_ADR_STATUS && wb_sel_i[0]) begin
      c_reg <= wb_dat_i[`SMIE_C_BIT];
      z_reg <= wb_dat_i[`SMIE_Z_BIT];
    end
  end

  // ****************************************
  // Pointers
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ptr0_reg <= `SMIE_RST_PTR;
    end else if (exec_fire && ins.op == SMIE_OP_INDIRECT_LOAD_OP && !ins.n) begin
      ptr0_reg <= prsp.ptr_next;
    end else if (wr_now && !in_mem && wb_adr_i == `SMIE_ADR_PTR0) begin
      ptr0_reg <= smie_merge16(ptr0_reg, wb_dat_i[15:0], wb_sel_i[1:0]);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ptr1_reg <= `SMIE_RST_PTR;
    end else if (exec_fire && ins.op == SMIE_OP_INDIRECT_LOAD_OP && ins.n) begin
      ptr1_reg <= prsp.ptr_next;
    end else if (wr_now && !in_mem && wb_adr_i == `SMIE_ADR_PTR1) begin
      ptr1_reg <= smie_merge16(ptr1_reg, wb_dat_i[15:0], wb_sel_i[1:0]);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      eaddr_reg <= `SMIE_RST_PTR;
    end else if (exec_fire && ins.op == SMIE_OP_INDIRECT_LOAD_OP) begin
      eaddr_reg <= prsp.ea;
    end
  end

  // ****************************************
  // Data store
  // ****************************************
  // The store has no reset; software loads it through the memory window.
  always_ff @(posedge clk_i) begin
    if (exec_fire && ins.d && (ins.op == SMIE_OP_LSR || ins.op == SMIE_OP_MOVE_FILE_OP)) begin
      mem_reg[faddr] <= (ins.op == SMIE_OP_LSR) ? lsr_res : src;
    end else if (wr_now && in_mem && wb_sel_i[0]) begin
      mem_reg[wb_adr_i[8:2]] <= wb_dat_i[7:0];
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic lsr_x;
  logic move_file_op_x;
  logic indirect_load_op_x;
  assign lsr_x = exec_fire && ins.op == SMIE_OP_LSR;
  assign move_file_op_x = exec_fire && ins.op == SMIE_OP_MOVE_FILE_OP;
  assign indirect_load_op_x = exec_fire && ins.op == SMIE_OP_INDIRECT_LOAD_OP;

  property p_lsr_shape;
    lsr_x && !ins.d |=> w_reg == {1'b0, $past(src[7:1])};
  endproperty
  a_lsr_shape: assert property (p_lsr_shape) else $error("shift result wrong");

  property p_lsr_carry;
    lsr_x |=> c_reg == $past(src[0]);
  endproperty
  a_lsr_carry: assert property (p_lsr_carry) else $error("carry not from bit 0");

  property p_lsr_file;
    lsr_x && ins.d |=> w_reg == $past(w_reg) && mem_reg[$past(faddr)] == $past(lsr_res);
  endproperty
  a_lsr_file: assert property (p_lsr_file) else $error("shift write-back wrong");

  property p_move_file_op_z;
    move_file_op_x |=> z_reg == ($past(src) == 8'h00);
  endproperty
  a_move_file_op_z: assert property (p_move_file_op_z) else $error("move zero flag wrong");

  property p_rel_ea;
    indirect_load_op_x && ins.rel |-> prsp.ea == ptr_sel + {{10{ins.k[5]}}, ins.k};
  endproperty
  a_rel_ea: assert property (p_rel_ea) else $error("offset address wrong");

  property p_pre_inc;
    indirect_load_op_x && !ins.rel && ins.mm == 2'b00 |-> prsp.ea == ptr_sel + 16'h0001;
  endproperty
  a_pre_inc: assert property (p_pre_inc) else $error("pre-increment address wrong");

  property p_load_w;
    indirect_load_op_x |=> w_reg == $past(ind_data) && z_reg == ($past(ind_data) == 8'h00);
  endproperty
  a_load_w: assert property (p_load_w) else $error("indirect load wrong");

  property p_ptr_keep;
    indirect_load_op_x && ins.rel && !ins.n |=> ptr0_reg == $past(ptr0_reg);
  endproperty
  a_ptr_keep: assert property (p_ptr_keep) else $error("offset form moved pointer");

  property p_win;
    move_file_op_x && ins.f == `SMIE_WIN1_F |-> src == mem_reg[ptr1_reg[6:0]];
  endproperty
  a_win: assert property (p_win) else $error("window not redirected");

  property p_wrap;
    indirect_load_op_x && !ins.rel && ins.mm[0] && !ins.n && ptr0_reg == 16'h0000
      |=> ptr0_reg == 16'hFFFF;
  endproperty
  a_wrap: assert property (p_wrap) else $error("pointer did not wrap");

  property p_carry_keep;
    indirect_load_op_x |=> c_reg == $past(c_reg);
  endproperty
  a_carry_keep: assert property (p_carry_keep) else $error("carry touched by load");

  c_lsr: cover property (lsr_x && ins.d);
  c_move_file_op: cover property (move_file_op_x && !ins.d);
  c_post_dec: cover property (indirect_load_op_x && !ins.rel && ins.mm == 2'b11);
  c_rel: cover property (indirect_load_op_x && ins.rel && ins.k[5]);

endmodule : smie_exec

// ==== include/smie_consts.svh ====
// Offsets, field positions and reset values of the shift/move/indirect execution block.
`ifndef SMIE_CONSTS_SVH
`define SMIE_CONSTS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define SMIE_ADR_INSTR 12'h000
`define SMIE_ADR_WREG 12'h004
`define SMIE_ADR_STATUS 12'h008
`define SMIE_ADR_PTR0 12'h00C
`define SMIE_ADR_PTR1 12'h010
`define SMIE_ADR_EADDR 12'h014
`define SMIE_MEM_SEL 3'h1

// ****************************************
// Instruction word fields
// ****************************************
`define SMIE_OP_HI 13
`define SMIE_OP_LO 12
`define SMIE_N_BIT 9
`define SMIE_REL_BIT 8
`define SMIE_D_BIT 7
`define SMIE_MM_HI 7
`define SMIE_MM_LO 6
`define SMIE_F_HI 6
`define SMIE_K_HI 5
`define SMIE_C_BIT 0
`define SMIE_Z_BIT 1
`define SMIE_WIN0_F 7'h00
`define SMIE_WIN1_F 7'h01

// ****************************************
// Reset values
// ****************************************
`define SMIE_RST_INSTR 16'h3000
`define SMIE_RST_BYTE 8'h00
`define SMIE_RST_PTR 16'h0000

`endif

// ==== include/smie_pkg.sv ====
// Types shared by the shift/move/indirect execution block.
package smie_pkg;

  typedef enum logic [1:0] {
    SMIE_ST_IDLE = 2'b00,
    SMIE_ST_EXEC = 2'b01
  } smie_state_e;

  typedef enum logic [1:0] {
    SMIE_OP_LSR = 2'b00,
    SMIE_OP_MOVE_FILE_OP = 2'b01,
    SMIE_OP_INDIRECT_LOAD_OP = 2'b10,
    SMIE_OP_NOP = 2'b11
  } smie_op_e;

  typedef struct packed {
    smie_op_e op;
    logic d;
    logic [6:0] f;
    logic n;
    logic rel;
    logic [1:0] mm;
    logic [5:0] k;
  } smie_instr_s;

  typedef struct packed {
    logic [15:0] ptr;
    logic rel;
    logic [1:0] mm;
    logic [5:0] k;
  } smie_ptr_req_s;

  typedef struct packed {
    logic [15:0] ea;
    logic [15:0] ptr_next;
  } smie_ptr_rsp_s;

endpackage : smie_pkg

// ==== logic/smie_ptr_unit.sv ====
// Effective address and pointer update for the indirect load.
`timescale 1ns/1ps
module smie_ptr_unit
  import smie_pkg::*;
(
  // Request and result
  input wire smie_ptr_req_s req_i,
  output smie_ptr_rsp_s rsp_o
);

  // Plain 16-bit arithmetic wraps at the ends of the range by itself.
  function automatic logic [15:0] smie_step(input logic [15:0] p, input logic down);
    smie_step = down ? p - 16'h0001 : p + 16'h0001;
  endfunction : smie_step

  logic [15:0] stepped;
  logic [15:0] k_ext;

  always_comb begin
    stepped = smie_step(req_i.ptr, req_i.mm[0]);
    k_ext = {{10{req_i.k[5]}}, req_i.k};
    if (req_i.rel) begin
      rsp_o.ea = req_i.ptr + k_ext;
      rsp_o.ptr_next = req_i.ptr;
    end else begin
      // pre modes use the stepped value
      rsp_o.ea = req_i.mm[1] ? req_i.ptr : stepped;
      rsp_o.ptr_next = stepped;
    end
  end

endmodule : smie_ptr_unit

// ==== dv/smie_wb_master.sv ====
// Wishbone classic master standing in for the core fetch and decode side.
`timescale 1ns/1ps
module smie_wb_master (
  // Clock
  input wire logic clk_i,
  // Wishbone master
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [11:0] adr_o,
  output logic [31:0] dat_o,
  output logic [3:0] sel_o,
  input wire logic ack_i,
  input wire logic [31:0] dat_i
);
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    adr_o = 12'hFFF;
    dat_o = 32'h0;
    sel_o = 4'h0;
  end

  // One classic cycle; waits for ack with no assumed latency.
  task automatic xfer(input logic we, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= we;
    adr_o <= a;
    dat_o <= d;
    sel_o <= 4'hF;
    do @(posedge clk_i); while (ack_i !== 1'b1);
    q = dat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    // Released lines show the inverse so a stale value is never mistaken for a live one.
    adr_o <= ~a;
    dat_o <= ~d;
    sel_o <= 4'h0;
  endtask : xfer
endmodule : smie_wb_master

// ==== dv/shift_move_indirect_exec_bench.sv ====
// Self-checking testbench for the shift, move and indirect load execution unit.
`timescale 1ns/1ps
`include "smie_consts.svh"
module shift_move_indirect_exec_bench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic ce_rand = 1'b0;
  logic wb_cyc, wb_stb, wb_we, wb_ack, busy;
  logic [11:0] wb_adr;
  logic [31:0] wb_dat_w, wb_dat_r;
  logic [3:0] wb_sel;
  int n_mismatch = 0;
  int checks_done = 0;
  int cycles = 0;
  logic [7:0] m_w = 8'h00;
  logic m_c = 1'b0;
  logic m_z = 1'b0;
  logic [15:0] m_ptr [2] = '{16'h0000, 16'h0000};
  logic [15:0] m_ea = 16'h0000;
  logic [7:0] mem [128];
  logic [15:0] ptab [5] = '{16'h0000, 16'hFFFF, 16'h0001, 16'hFFFE, 16'h8000};

  initial begin
    forever #50 clk_i = ~clk_i;
  end

  smie_wb_master bus (.clk_i(clk_i), .cyc_o(wb_cyc), .stb_o(wb_stb), .we_o(wb_we),
    .adr_o(wb_adr), .dat_o(wb_dat_w), .sel_o(wb_sel), .ack_i(wb_ack), .dat_i(wb_dat_r));

  smie_exec dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_dat_i(wb_dat_w),
    .wb_sel_i(wb_sel), .wb_dat_o(wb_dat_r), .wb_ack_o(wb_ack), .busy_o(busy));

  // Random clock-enable gaps, dropping ce_i about one cycle in four, stretch handshakes once the main run starts.
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    ce_i <= ce_rand ? ($urandom_range(3) != 0) : 1'b1;
    if (cycles == 40000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("mismatches %0d, checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus.xfer(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask : rd

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus.xfer(1'b1, a, d, q);
  endtask : wr

  // Model one instruction, launch it, then compare every visible result.
  task automatic run(input logic [15:0] ins);
    logic [6:0] i;
    logic [7:0] s, r;
    logic [15:0] p;
    i = (ins[6:0] == 7'h00) ? m_ptr[0][6:0] : (ins[6:0] == 7'h01) ? m_ptr[1][6:0] : ins[6:0];
    s = mem[i];
    r = (ins[13:12] == 2'b00) ? {1'b0, s[7:1]} : s;
    if (ins[13] == 1'b0) begin
      if (ins[12] == 1'b0) m_c = s[0];
      m_z = (r == 8'h00);
      if (ins[7]) mem[i] = r;
      else m_w = r;
    end else if (ins[12] == 1'b0) begin
      p = m_ptr[ins[9]];
      if (ins[8]) m_ea = p + {{10{ins[5]}}, ins[5:0]};
      else begin
        m_ea = ins[7] ? p : (ins[6] ? p - 16'h1 : p + 16'h1);
        m_ptr[ins[9]] = ins[6] ? p - 16'h1 : p + 16'h1;
      end
      i = m_ea[6:0];
      m_w = mem[i];
      m_z = (m_w == 8'h00);
    end
    wr(`SMIE_ADR_INSTR, {16'h0, ins});
    @(negedge clk_i);
    chk({31'h0, busy}, 32'h1);
    rd(`SMIE_ADR_WREG, {24'h0, m_w});
    rd(`SMIE_ADR_STATUS, {30'h0, m_z, m_c});
    rd(`SMIE_ADR_PTR0, {16'h0, m_ptr[0]});
    rd(`SMIE_ADR_PTR1, {16'h0, m_ptr[1]});
    rd(`SMIE_ADR_EADDR, {16'h0, m_ea});
    rd(12'h200 + {3'h0, i, 2'b00}, {24'h0, mem[i]});
    chk({31'h0, busy}, 32'h0);
  endtask : run

  initial begin
    logic [15:0] ins;
    void'($urandom(32'h37CC));
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int a = 0; a <= 24; a += 4) rd(a[11:0], (a == 0) ? 32'h3000 : 32'h0);
    wr(12'h018, 32'hFFFFFFFF);
    rd(12'h018, 32'h0);
    wr(`SMIE_ADR_EADDR, 32'h0000FFFF);
    rd(`SMIE_ADR_EADDR, 32'h0);
    for (int i = 0; i < 128; i++) begin
      mem[i] = ($urandom_range(3) == 0) ? 8'h00 : 8'($urandom);
      wr(12'h200 + {3'h0, i[6:0], 2'b00}, {24'h0, mem[i]});
    end
    ce_rand = 1'b1;
    for (int t = 0; t < 400; t++) begin
      if (t < 16 || $urandom_range(1) == 0) begin
        m_ptr[0] = (t < 16) ? ptab[t[0]] : ptab[$urandom_range(4)];
        m_ptr[1] = (t < 16) ? ptab[t[0]] : 16'($urandom);
        wr(`SMIE_ADR_PTR0, {16'h0, m_ptr[0]});
        wr(`SMIE_ADR_PTR1, {16'h0, m_ptr[1]});
      end
      m_w = 8'($urandom);
      {m_z, m_c} = 2'($urandom);
      wr(`SMIE_ADR_WREG, {24'h0, m_w});
      wr(`SMIE_ADR_STATUS, {30'h0, m_z, m_c});
      ins = {2'b00, 2'($urandom), 2'b00, 10'($urandom)};
      // The first sixteen run the shift on file 7'h1F or 7'h60, to W and to file, with both pointers at 0000 or FFFF.
      if (t < 16) ins = {6'h02, t[0], t[3], t[2:1], t[1] ? 6'h20 : 6'h1F};
      run(ins);
    end
    wrap_up();
  end
endmodule : shift_move_indirect_exec_bench
